// ===== logic/cio_io_edge.sv
// One chip edge of configurable io cells with its wide decoders
//
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module cio_io_edge
	import cio_pkg::*;
(
	input  wire logic                core_clk,
	input  wire logic                resetn,
	input  wire cio_bus_s            bus,
	output logic       [DW-1:0]      rdata,
	input  wire logic                io_clk_net,
	input  wire logic                gsr,
	input  wire logic [NCELL-1:0]    core_out,
	input  wire logic [NCELL-1:0]    core_oe_ctl,
	input  wire logic [NLOCAL-1:0]   local_in,
	input  wire logic [NCELL-1:0]    pad_in,
	output logic       [NCELL-1:0]   pad_out,
	output logic       [NCELL-1:0]   pad_oe,
	output logic       [NCELL-1:0]   pull_up_en,
	output logic       [NCELL-1:0]   pull_down_en,
	output logic       [NCELL-1:0]   input_tap_one,
	output logic       [NCELL-1:0]   input_tap_two,
	output logic       [2*NDEC-1:0]  dec_out
);

	typedef logic [IN_DELAY_CYC-1:0] cio_dly_t;

	// State of the edge in one record, decoder outputs apart
	typedef struct packed {
		logic                         done;
		logic                         clk_prev;
		cio_cell_cfg_s [NCELL-1:0]    cell_cfg;
		cio_dec_cfg_s  [NDEC-1:0]     dec_cfg;
		logic          [NCELL-1:0]    sync1;
		logic          [NCELL-1:0]    sync2;
		cio_dly_t      [NCELL-1:0]    dly;
		logic          [NCELL-1:0]    master;
		logic          [NCELL-1:0]    slave;
		logic          [NCELL-1:0]    out_ff;
		logic          [NCELL-1:0]    tap1;
		logic          [NCELL-1:0]    tap2;
		logic          [NCELL-1:0]    pad_out;
		logic          [NCELL-1:0]    pad_oe;
		logic          [NCELL-1:0]    pull_up;
		logic          [NCELL-1:0]    pull_down;
		logic          [DW-1:0]       rdata;
	} cio_edge_state_s;

	cio_edge_state_s   st_reg;
	cio_edge_state_s   st_next;
	logic              rise;
	logic              fall;
	logic              load_init;
	logic              force_init;
	logic              cfg_open;
	logic              in_edge;
	logic              in_level;
	logic              out_edge;
	logic              in_d;
	logic [2:0]        cell_idx;
	logic [1:0]        dec_idx;
	logic [NDECIN-1:0] dec_in;

	// Pick the source of one input tap
	function automatic logic tap_pick(input cio_tap_e sel,
			input logic pin, input logic mst, input logic slv);
		case (sel)
			TAP_PIN: tap_pick = pin;
			TAP_MASTER: tap_pick = mst;
			TAP_SLAVE: tap_pick = slv;
			default: tap_pick = 1'b0;
		endcase
	endfunction : tap_pick

	assign cell_idx = bus.addr[4:2];
	assign dec_idx = bus.addr[3:2];
	assign dec_in = {local_in, st_reg.tap1};

	// Wide decoders fed by the first taps and local lines
	for (genvar d = 0; d < NDEC; d++) begin : g_dec
		cio_wide_decoder u_dec (
			.core_clk (core_clk),
			.resetn   (resetn),
			.cfg      (st_reg.dec_cfg[d]),
			.dec_in   (dec_in),
			.dec_out  (dec_out[2*d+1:2*d])
		);
	end

	// Next state of configuration, cells and bus
	always_comb begin
		st_next = st_reg;
		rise = io_clk_net & ~st_reg.clk_prev;
		fall = ~io_clk_net & st_reg.clk_prev;
		st_next.clk_prev = io_clk_net;
		cfg_open = ~st_reg.done;
		load_init = 1'b0;
		in_edge = 1'b0;
		in_level = 1'b0;
		out_edge = 1'b0;
		in_d = 1'b0;
		force_init = gsr & st_reg.done;

		// Control write; done rising is the end of configuration
		if (bus.wr && bus.addr == CTRL_OFS) begin
			st_next.done = bus.wdata[CTRL_DONE_BIT];
			load_init = bus.wdata[CTRL_DONE_BIT] & ~st_reg.done;
		end

		// Options only change while the edge is unconfigured
		if (bus.wr && cfg_open && cell_hit(bus.addr)) begin
			st_next.cell_cfg[cell_idx] =
				bus.wdata[$bits(cio_cell_cfg_s)-1:0];
		end
		if (bus.wr && cfg_open && dec_hit(bus.addr)) begin
			st_next.dec_cfg[dec_idx] =
				bus.wdata[$bits(cio_dec_cfg_s)-1:0];
		end

		// Pin samples pass two flops before any use
		st_next.sync1 = pad_in;
		st_next.sync2 = st_reg.sync1;

		for (int i = 0; i < NCELL; i++) begin
			// Per-flop edge choice on the shared io clock net
			in_edge = st_reg.cell_cfg[i].in_neg ? fall : rise;
			in_level = st_reg.cell_cfg[i].in_neg ?
				~io_clk_net : io_clk_net;
			out_edge = st_reg.cell_cfg[i].out_neg ? fall : rise;

			// Default long setup inserts the delay line
			st_next.dly[i] = {st_reg.dly[i][IN_DELAY_CYC-2:0],
				st_reg.sync2[i]};
			in_d = st_reg.cell_cfg[i].short_setup_attribute ?
				st_reg.sync2[i] :
				st_reg.dly[i][IN_DELAY_CYC-1];

			// Input register: master open off the active level
			if (load_init || force_init) begin
				st_next.master[i] = st_reg.cell_cfg[i].in_init;
				st_next.slave[i] = st_reg.cell_cfg[i].in_init;
			end else if (st_reg.done) begin
				if (!in_level) begin
					st_next.master[i] = in_d;
				end
				if (st_reg.cell_cfg[i].in_latch) begin
					if (in_level) begin
						st_next.slave[i] = in_d;
					end
				end else if (in_edge) begin
					st_next.slave[i] = st_reg.master[i];
				end
			end

			// Output flop captures the core signal on its edge
			if (load_init || force_init) begin
				st_next.out_ff[i] = st_reg.cell_cfg[i].out_init;
			end else if (st_reg.done && out_edge) begin
				st_next.out_ff[i] = core_out[i];
			end

			// Taps toward the core
			st_next.tap1[i] = tap_pick(st_reg.cell_cfg[i].tap1_sel,
				st_reg.sync2[i], st_reg.master[i],
				st_reg.slave[i]);
			st_next.tap2[i] = tap_pick(st_reg.cell_cfg[i].tap2_sel,
				st_reg.sync2[i], st_reg.master[i],
				st_reg.slave[i]);

			// Output path select
			case (st_reg.cell_cfg[i].out_sel)
				OUT_DIRECT: st_next.pad_out[i] = core_out[i];
				OUT_INVERT: st_next.pad_out[i] = ~core_out[i];
				OUT_REG: st_next.pad_out[i] = st_reg.out_ff[i];
				OUT_DEC: st_next.pad_out[i] =
					dec_out[st_reg.cell_cfg[i].dec_src];
				default: st_next.pad_out[i] = 1'b0;
			endcase

			// Driver stays off until configured
			st_next.pad_oe[i] = st_reg.done &
				~(core_oe_ctl[i] ^ st_reg.cell_cfg[i].oe_pol);

			// Configuration forces the pull-up regardless of choice
			st_next.pull_up[i] = ~st_reg.done |
				(st_reg.cell_cfg[i].pull == PULL_UP);
			st_next.pull_down[i] = st_reg.done &
				(st_reg.cell_cfg[i].pull == PULL_DOWN);
		end

		// Read data stand in the cycle after the strobe only
		st_next.rdata = '0;
		if (bus.rd) begin
			if (bus.addr == CTRL_OFS) begin
				st_next.rdata[CTRL_DONE_BIT] = st_reg.done;
				st_next.rdata[CTRL_GSR_BIT] = gsr;
			end else if (bus.addr == STATUS_OFS) begin
				st_next.rdata[ST_PIN_POS +: NCELL] = st_reg.sync2;
				st_next.rdata[ST_TAP1_POS +: NCELL] = st_reg.tap1;
				st_next.rdata[ST_TAP2_POS +: NCELL] = st_reg.tap2;
				st_next.rdata[ST_DEC_POS +: 2*NDEC] = dec_out;
			end else if (cell_hit(bus.addr)) begin
				st_next.rdata[$bits(cio_cell_cfg_s)-1:0] =
					st_reg.cell_cfg[cell_idx];
			end else if (dec_hit(bus.addr)) begin
				st_next.rdata[$bits(cio_dec_cfg_s)-1:0] =
					st_reg.dec_cfg[dec_idx];
			end
		end
	end

	// Reset leaves the edge unconfigured with all pins pulled up
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			st_reg <= '0;
			st_reg.cell_cfg <= {NCELL{CELL_CFG_RST}};
			st_reg.dec_cfg <= {NDEC{DEC_CFG_RST}};
			st_reg.pull_up <= '1;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from flops
	assign rdata = st_reg.rdata;
	assign pad_out = st_reg.pad_out;
	assign pad_oe = st_reg.pad_oe;
	assign pull_up_en = st_reg.pull_up;
	assign pull_down_en = st_reg.pull_down;
	assign input_tap_one = st_reg.tap1;
	assign input_tap_two = st_reg.tap2;

endmodule : cio_io_edge

`default_nettype wire

// ===== logic/cio_pkg.sv
// Shared constants, types and decode helpers for the configurable io block
package cio_pkg;

	// Array sizes
	localparam int NCELL = 8;              // io cells on this edge
	localparam int NLOCAL = 4;             // local lines into the decoders
	localparam int NDECIN = NCELL + NLOCAL; // decoder input width
	localparam int HALF = NDECIN / 2;      // split point of a decoder
	localparam int NDEC = 4;               // wide decoders per edge

	// Register bus widths
	localparam int AW = 8;
	localparam int DW = 32;

	// Register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] CELL_BASE = 8'h20;
	localparam logic [7:0] DEC_BASE = 8'h40;

	// Control register field positions
	localparam int CTRL_DONE_BIT = 0;
	localparam int CTRL_GSR_BIT = 1;

	// Status register field positions
	localparam int ST_PIN_POS = 0;
	localparam int ST_TAP1_POS = 8;
	localparam int ST_TAP2_POS = 16;
	localparam int ST_DEC_POS = 24;

	// Input data delay, as a time and as cycles of the 40 MHz clock
	localparam int CLK_PERIOD_NS = 25;
	localparam int IN_DELAY_NS = 50;
	localparam int IN_DELAY_CYC =
		(IN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Output path choices
	typedef enum logic [1:0] {
		OUT_DIRECT,
		OUT_INVERT,
		OUT_REG,
		OUT_DEC
	} cio_out_e;

	// Input tap sources
	typedef enum logic [1:0] {
		TAP_PIN,
		TAP_MASTER,
		TAP_SLAVE,
		TAP_OFF
	} cio_tap_e;

	// Pin resistor choices
	typedef enum logic [1:0] {
		PULL_NONE,
		PULL_UP,
		PULL_DOWN,
		PULL_RSVD
	} cio_pull_e;

	// Per-cell configuration word, low bits first from out_sel
	typedef struct packed {
		logic [2:0] dec_src;   // decoder output fed to the pad
		logic       in_neg;    // input flop acts on falling edge
		logic       out_neg;   // output flop acts on falling edge
		logic       in_init;   // input flop initial state
		logic       out_init;  // output flop initial state
		cio_tap_e   tap2_sel;
		cio_tap_e   tap1_sel;
		logic       in_latch;  // input register as transparent latch
		logic       short_setup_attribute;
		cio_pull_e  pull;
		logic       oe_pol;    // 1: high control enables driver
		cio_out_e   out_sel;
	} cio_cell_cfg_s;

	// Per-decoder configuration word
	typedef struct packed {
		logic              split;
		logic [NDECIN-1:0] inv;   // take input complemented
		logic [NDECIN-1:0] use_in; // input takes part in the AND
	} cio_dec_cfg_s;

	localparam cio_cell_cfg_s CELL_CFG_RST = '0;
	localparam cio_dec_cfg_s DEC_CFG_RST = '0;

	// Register bus request
	typedef struct packed {
		logic [AW-1:0] addr;
		logic [DW-1:0] wdata;
		logic          wr;
		logic          rd;
	} cio_bus_s;

	// Hit on a cell configuration word
	function automatic logic cell_hit(input logic [AW-1:0] a);
		cell_hit = (a[7:5] == CELL_BASE[7:5]) && (a[1:0] == 2'h0);
	endfunction : cell_hit

	// Hit on a decoder configuration word
	function automatic logic dec_hit(input logic [AW-1:0] a);
		dec_hit = (a[7:4] == DEC_BASE[7:4]) && (a[1:0] == 2'h0);
	endfunction : dec_hit

endpackage : cio_pkg

// ===== logic/cio_wide_decoder.sv
// One wide edge decoder with optional split at its centre
`timescale 1ns/1ps
`default_nettype none

module cio_wide_decoder
	import cio_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic              resetn,
	input  wire cio_dec_cfg_s      cfg,
	input  wire logic [NDECIN-1:0] dec_in,
	output logic       [1:0]       dec_out
);

	typedef struct packed {
		logic [1:0] out;
	} cio_dec_state_s;

	cio_dec_state_s st_reg;
	cio_dec_state_s st_next;
	logic [NDECIN-1:0] term;
	logic              lo_and;
	logic              hi_and;

	// Unused inputs count as true so they never pull the AND low
	always_comb begin
		st_next = st_reg;
		term = (dec_in ^ cfg.inv) | ~cfg.use_in;
		lo_and = &term[HALF-1:0];
		hi_and = &term[NDECIN-1:HALF];
		if (cfg.split) begin
			st_next.out = {hi_and, lo_and};
		end else begin
			st_next.out = {2{lo_and & hi_and}};
		end
	end

	// Registered so the pin and core see a clean level
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign dec_out = st_reg.out;

endmodule : cio_wide_decoder

`default_nettype wire

// ===== sim/cio_io_edge_asserts.sv
// Port-level checker for one configurable io edge
`timescale 1ns/1ps
`default_nettype none

module cio_io_edge_asserts
	import cio_pkg::*;
(
	input wire logic              core_clk,
	input wire logic              resetn,
	input wire cio_bus_s          bus,
	input wire logic [DW-1:0]     rdata,
	input wire logic              gsr,
	input wire logic [NCELL-1:0]  pad_oe,
	input wire logic [NCELL-1:0]  pull_up_en,
	input wire logic [NCELL-1:0]  pull_down_en,
	input wire logic [NCELL-1:0]  input_tap_one,
	input wire logic [NCELL-1:0]  input_tap_two,
	input wire logic [2*NDEC-1:0] dec_out
);
	logic done_reg;

	// Shadow of the done bit, since writes to it are never refused
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			done_reg <= 1'b0;
		else if (bus.wr && bus.addr == CTRL_OFS)
			done_reg <= bus.wdata[CTRL_DONE_BIT];
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	cfg_pullup_a: assert property (!$past(done_reg) |->
		pull_up_en == '1 && pull_down_en == '0) else $error("pull wrong");
	cfg_no_drive_a: assert property (!$past(done_reg) |->
		pad_oe == '0) else $error("pad driven while configuring");
	one_pull_a: assert property (
		(pull_up_en & pull_down_en) == '0) else $error("both pulls on");
	idle_rdata_a: assert property (!$past(bus.rd) |->
		rdata == '0) else $error("read data outside its cycle");
	ctrl_read_a: assert property (bus.rd && bus.addr == CTRL_OFS |=>
		rdata == {30'h0, $past(gsr), done_reg}) else $error("ctrl read");
	status_read_a: assert property (bus.rd && bus.addr == STATUS_OFS
		|=> rdata[31:8] == {$past(dec_out), $past(input_tap_two),
		$past(input_tap_one)}) else $error("status read");
	unmapped_rd_a: assert property (bus.rd && bus.addr >= 8'h50 |=>
		rdata == '0) else $error("unmapped read not zero");
	cell_rsvd_a: assert property (bus.rd && bus.addr[7:5] == 3'h1
		|=> rdata[31:18] == '0) else $error("cell reserved bits");
	dec_rsvd_a: assert property (bus.rd && bus.addr[7:4] == 4'h4
		|=> rdata[31:25] == '0) else $error("decoder reserved bits");
endmodule : cio_io_edge_asserts

bind cio_io_edge cio_io_edge_asserts u_asserts (.core_clk, .resetn, .bus,
	.rdata, .gsr, .pad_oe, .pull_up_en, .pull_down_en, .input_tap_one,
	.input_tap_two, .dec_out);

`default_nettype wire

// ===== sim/cio_pin_model.sv
// Board side of the pads: drivers, pull resistors and floating lines
`timescale 1ns/1ps
`default_nettype none

module cio_pin_model
	import cio_pkg::*;
(
	input  wire logic             core_clk,
	input  wire logic [NCELL-1:0] pad_out,
	input  wire logic [NCELL-1:0] pad_oe,
	input  wire logic [NCELL-1:0] pull_up_en,
	input  wire logic [NCELL-1:0] pull_down_en,
	input  wire logic [NCELL-1:0] ext_en,
	input  wire logic [NCELL-1:0] ext_val,
	output logic      [NCELL-1:0] pad_in
);
	logic [NCELL-1:0] float_reg = 8'h55;

	// A floating pad keeps changing so a stale level never passes
	always @(posedge core_clk)
		float_reg <= ~float_reg;

	// Cell driver first, board driver next, then the resistors
	always_comb begin
		for (int i = 0; i < NCELL; i++) begin
			if (pad_oe[i])
				pad_in[i] = pad_out[i];
			else if (ext_en[i])
				pad_in[i] = ext_val[i];
			else if (pull_up_en[i] | pull_down_en[i])
				pad_in[i] = pull_up_en[i];
			else
				pad_in[i] = float_reg[i];
		end
	end
endmodule : cio_pin_model

`default_nettype wire

// ===== sim/cio_io_edge_tb_top.sv
// Self-checking bench for one io edge: reset checks, table cases, then hand tests
`timescale 1ns/1ps
`default_nettype none

module cio_io_edge_tb_top
	import cio_pkg::*;
;
	typedef struct packed {
		logic [17:0] w;  // cell 0 configuration
		logic        co; // core data
		logic        oc; // three-state control
		logic [3:0]  e;  // pad_out, pad_oe, pull up, pull down
	} cio_row_s;

	logic              core_clk = 1'b0;
	logic              resetn = 1'b0;
	cio_bus_s          bus = '0;
	logic              io_clk_net = 1'b0;
	logic              gsr = 1'b0;
	logic [NCELL-1:0]  core_out = '0;
	logic [NCELL-1:0]  core_oe_ctl = '0;
	logic [NLOCAL-1:0] local_in = '0;
	logic [NCELL-1:0]  ext_en = '0;
	logic [NCELL-1:0]  ext_val = '0;
	logic [NCELL-1:0]  pad_in, pad_out, pad_oe, pull_up_en, pull_down_en;
	logic [NCELL-1:0]  input_tap_one, input_tap_two;
	logic [DW-1:0]     rdata;
	logic [2*NDEC-1:0] dec_out;
	int                mismatches = 0;
	int                n_checks = 0;
	cio_row_s rows [7] = '{'{18'hC, 1'b1, 1'b1, 4'hE},
		'{18'h11, 1'b1, 1'b0, 4'h5}, '{18'h0, 1'b0, 1'b1, 4'h0},
		'{18'h5, 1'b0, 1'b0, 4'h8}, '{18'h802, 1'b0, 1'b0, 4'hC},
		'{18'h2, 1'b1, 1'b1, 4'h0}, '{18'h3, 1'b0, 1'b0, 4'hC}};
	logic [DW-1:0] dcfg [3] = '{32'h100, 32'h100100, 32'h1000100};

	always #12.5 core_clk = ~core_clk;

	cio_io_edge DUT (.core_clk, .resetn, .bus, .rdata, .io_clk_net, .gsr,
		.core_out, .core_oe_ctl, .local_in, .pad_in, .pad_out, .pad_oe,
		.pull_up_en, .pull_down_en, .input_tap_one, .input_tap_two,
		.dec_out);
	cio_pin_model u_pins (.core_clk, .pad_out, .pad_oe, .pull_up_en,
		.pull_down_en, .ext_en, .ext_val, .pad_in);

	task automatic ck(input logic [DW-1:0] got, exp, input string m);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got,
				exp);
		end
	endtask : ck

	task automatic wt(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : wt

	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge core_clk);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge core_clk);
		bus.wr <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task automatic rd_ck(input logic [AW-1:0] a, input logic [DW-1:0] e);
		@(posedge core_clk);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge core_clk);
		bus.rd <= 1'b0;
		#1 ck(rdata, e, "read");
	endtask : rd_ck

	// Reopen configuration, load cell 0, then finish configuring
	task automatic cfg(input logic [DW-1:0] w);
		wr(CTRL_OFS, 32'h0);
		wr(CELL_BASE, w);
		wr(CTRL_OFS, 32'h1);
		wt(4);
	endtask : cfg

	task automatic io_edge(input logic lv, input int n);
		@(posedge core_clk);
		io_clk_net <= lv;
		wt(n);
	endtask : io_edge

	task automatic test_done;
		$display("TB: checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : test_done

	// Watchdog: the whole run needs well under a thousand cycles
	initial begin
		#100000;
		mismatches++;
		test_done();
	end

	initial begin
		logic              v;
		logic [2*NDEC-1:0] ex;
		repeat (4) @(posedge core_clk);
		resetn <= 1'b1;
		wt(1);
		ck({pull_up_en, pad_oe, pull_down_en}, 24'hFF0000, "rst");
		rd_ck(CELL_BASE, '0);
		rd_ck(8'h60, '0);
		$display("TB: reset test over");
		// Output paths, enable polarity and pulls, one row per setup
		foreach (rows[i]) begin
			@(posedge core_clk);
			core_out[0] <= rows[i].co;
			core_oe_ctl[0] <= rows[i].oc;
			cfg(rows[i].w);
			ck({pad_out[0], pad_oe[0], pull_up_en[0], pull_down_en[0]},
				rows[i].e, "row");
		end
		$display("TB: table test over");
		// Output flop: rising capture, set/reset back to init, then falling
		cfg(32'h802);
		io_edge(1'b1, 4);
		ck(pad_out[0], 1'b0, "out flop rise");
		@(posedge core_clk);
		gsr <= 1'b1;
		wt(3);
		ck(pad_out[0], 1'b1, "gsr");
		rd_ck(CTRL_OFS, 32'h3);
		io_edge(1'b0, 2);
		@(posedge core_clk);
		gsr <= 1'b0;
		core_out[0] <= 1'b1;
		cfg(32'h2002);
		io_edge(1'b1, 4);
		ck(pad_out[0], 1'b0, "fall flop on rise");
		io_edge(1'b0, 4);
		ck(pad_out[0], 1'b1, "fall flop on fall");
		wr(CELL_BASE, 32'h3);
		rd_ck(CELL_BASE, 32'h2002);
		$display("TB: flop test over");
		// Input delay seen through the master tap; the pin tap has none
		@(posedge core_clk);
		ext_en[0] <= 1'b1;
		cfg(32'h84);
		@(posedge core_clk);
		ext_val[0] <= 1'b1;
		wt(4);
		ck(input_tap_one[0], 1'b0, "long setup early");
		wt(2);
		ck(input_tap_one[0], 1'b1, "long setup");
		cfg(32'hA4);
		@(posedge core_clk);
		ext_val[0] <= 1'b0;
		wt(4);
		ck(input_tap_one[0], 1'b0, "short setup");
		// Tap one from master, tap two from slave, slave starts set
		cfg(32'h14A4);
		ck(input_tap_two[0], 1'b1, "in init");
		io_edge(1'b1, 1);
		@(posedge core_clk);
		ext_val[0] <= 1'b1;
		wt(5);
		ck({input_tap_one[0], input_tap_two[0]}, 2'h0, "held");
		io_edge(1'b0, 5);
		ck({input_tap_one[0], input_tap_two[0]}, 2'h2, "open");
		// Latch mode: slave follows the data while the io clock is high
		cfg(32'h464);
		io_edge(1'b1, 3);
		ck(input_tap_two[0], 1'b1, "latch open");
		@(posedge core_clk);
		ext_val[0] <= 1'b0;
		wt(4);
		ck(input_tap_two[0], 1'b0, "latch follows");
		$display("TB: input test over");
		// Decoders: plain, complemented and split, all four alike
		wr(CTRL_OFS, 32'h0);
		for (int k = 0; k < 3; k++) begin
			for (int d = 0; d < NDEC; d++)
				wr(DEC_BASE + 8'(4 * d), dcfg[k]);
			for (int l = 0; l < 2; l++) begin
				@(posedge core_clk);
				local_in[0] <= l[0];
				wt(3);
				v = l[0] ^ (k == 1);
				ex = {NDEC{(k == 2) ? {v, 1'b1} : {v, v}}};
				ck(dec_out, ex, "dec");
			end
		end
		rd_ck(DEC_BASE + 8'hC, dcfg[2]);
		// Unconfigured: pulled-up pins read high, pin 0 held low by board
		rd_ck(STATUS_OFS, 32'hFFFEFEFE);
		$display("TB: decoder test over");
		// A second reset clears configuration
		@(posedge core_clk);
		resetn <= 1'b0;
		wt(2);
		ck({pull_up_en, pad_oe}, 16'hFF00, "reset again");
		@(posedge core_clk);
		resetn <= 1'b1;
		rd_ck(CTRL_OFS, '0);
		$display("TB: second reset test over");
		test_done();
	end
endmodule : cio_io_edge_tb_top

`default_nettype wire
